// ---- cc_detect_pkg.sv ----
// Constants, register map and carrier types for CC and bus-voltage detection
package cc_detect_pkg;

  // Timing: the debounce unit is derived from the system clock rate
  localparam int unsigned CLK_KHZ = 25000;
  localparam int unsigned DEB_UNIT_US = 100;
  localparam int unsigned DEB_UNIT_CYCLES = DEB_UNIT_US * CLK_KHZ / 1000;
  localparam int unsigned TICK_CNT_W = 12;

  // Widths
  localparam int unsigned CC_THR_N = 4;
  localparam int unsigned VB_THR_N = 2;
  localparam int unsigned DEB_W = 8;
  localparam int unsigned DAC_W = 10;

  // Register byte offsets
  localparam logic [7:0] OFF_CC_CONTROL = 8'h00;
  localparam logic [7:0] OFF_BUS_VOLTAGE_CONTROL = 8'h04;
  localparam logic [7:0] OFF_MATCH_DEBOUNCE = 8'h08;
  localparam logic [7:0] OFF_BUS_VOLTAGE_DEBOUNCE = 8'h0C;
  localparam logic [7:0] OFF_PD_SETTLE_DEBOUNCE = 8'h10;
  localparam logic [7:0] OFF_DEBOUNCE_CLEAR_EN = 8'h14;
  localparam logic [7:0] OFF_SAMPLE_EN = 8'h18;
  localparam logic [7:0] OFF_PIN_IRQ_EN = 8'h1C;
  localparam logic [7:0] OFF_BUS_THR_ZERO = 8'h20;
  localparam logic [7:0] OFF_BUS_THR_ONE = 8'h24;
  localparam logic [7:0] OFF_PIN_RESULT = 8'h28;
  localparam logic [7:0] OFF_PIN_CHANGE = 8'h2C;
  localparam logic [7:0] OFF_BUS_RESULT = 8'h30;
  localparam logic [7:0] OFF_BUS_CHANGE = 8'h34;
  localparam logic [7:0] OFF_BUS_IRQ_EN = 8'h38;
  localparam logic [7:0] OFF_CC_IRQ_STATUS = 8'h3C;
  localparam logic [7:0] OFF_CC_IRQ_EN = 8'h40;
  localparam logic [7:0] OFF_POWER_IRQ_STATUS = 8'h44;
  localparam logic [7:0] OFF_POWER_IRQ_EN = 8'h48;
  localparam logic [7:0] OFF_TOP_STATUS = 8'h4C;
  localparam logic [7:0] OFF_TOP_IRQ_EN = 8'h50;
  localparam logic [7:0] OFF_CLOCK_CONTROL = 8'h54;

  // Field positions in cc_control
  localparam int unsigned CCC_CMP_LSB = 0;
  localparam int unsigned CCC_DEB_EN = 2;
  localparam int unsigned CCC_PD1_LSB = 3;
  localparam int unsigned CCC_PD2_LSB = 5;
  localparam int unsigned CCC_COMM_SEL = 7;
  localparam int unsigned CCC_SINK = 8;
  localparam int unsigned CCC_W = 9;

  // Field positions in bus_voltage_control
  localparam int unsigned BVC_CMP_LSB = 0;
  localparam int unsigned BVC_DEB_EN = 2;
  localparam int unsigned BVC_W = 3;

  // Comparator control code that stops sampling
  localparam logic [1:0] CMP_STOP = 2'h0;

  // Values after reset
  localparam logic [CCC_W-1:0] CC_CONTROL_RST = 9'h000;
  localparam logic [BVC_W-1:0] BUS_CONTROL_RST = 3'h0;
  localparam logic [DEB_W-1:0] DEBOUNCE_RST = 8'h10;
  localparam logic [DAC_W-1:0] BUS_THR_RST = 10'h000;
  localparam logic CLOCK_CONTROL_RST = 1'b1;

  // Raw comparator outputs from the analog front end
  typedef struct packed {
    logic [VB_THR_N-1:0] vbus;
    logic [CC_THR_N-1:0] pin2;
    logic [CC_THR_N-1:0] pin1;
  } cmp_sample_t;

  // Termination and routing controls to the analog front end
  typedef struct packed {
    logic comm_sel;
    logic [1:0] pin2_pulldown;
    logic [1:0] pin1_pulldown;
    logic pin2_pulldown_en;
    logic pin1_pulldown_en;
  } term_ctl_t;

endpackage

// ---- port_partner.sv ----
// Source-side partner model driving the comparator outputs
`timescale 1ns/10ps
`default_nettype none
module port_partner (
  input wire logic clk,
  input wire logic attach,
  input wire logic vbus_on,
  input wire logic [1:0] level,
  input wire logic [1:0] cc_cmp_select,
  input wire logic bus_cmp_on,
  input wire cc_detect_pkg::term_ctl_t term,
  output cc_detect_pkg::cmp_sample_t cmp_raw
);
  logic [3:0] junk_r = 4'h5;
  wire [3:0] adv;
  // Unselected comparators never hold a stable value
  always_ff @(posedge clk) junk_r <= ~junk_r;
  // Pull-up seen only through the sink pull-down; thermometer of level
  assign adv = (attach && term.pin1_pulldown_en) ? 4'h7 >> (2'h3 - level)
    : 4'h0;
  // Source drives the bus above both thresholds when powered
  assign cmp_raw = {bus_cmp_on ? {2{vbus_on}} : junk_r[1:0],
    cc_cmp_select[1] ? 4'h0 : ~junk_r, cc_cmp_select[0] ? adv : junk_r};
endmodule
`default_nettype wire

// ---- sink_cc_vbus_attach_detect.sv ----
// Sink-side CC and bus-voltage attach/detach detection with APB registers
//
// Local design decisions: the APB register port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module sink_cc_vbus_attach_detect (
  input wire logic clk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire cc_detect_pkg::cmp_sample_t cmp_raw,
  output cc_detect_pkg::term_ctl_t term,
  output logic [1:0] cc_cmp_select,
  output logic bus_cmp_on,
  output logic [cc_detect_pkg::DAC_W-1:0] bus_thr_zero,
  output logic [cc_detect_pkg::DAC_W-1:0] bus_thr_one,
  output logic hf_osc_en,
  output logic [1:0] charge_level,
  output logic irq_n
);

  localparam int NT = cc_detect_pkg::CC_THR_N;
  localparam int NV = cc_detect_pkg::VB_THR_N;
  localparam int DW = cc_detect_pkg::DEB_W;

  // Control registers
  logic [cc_detect_pkg::CCC_W-1:0] cc_control_r;
  logic [cc_detect_pkg::BVC_W-1:0] bus_voltage_control_r;
  logic [DW-1:0] match_debounce_time_r;
  logic [DW-1:0] bus_voltage_debounce_time_r;
  logic [DW-1:0] pd_settle_debounce_time_r;
  logic [NT-1:0] threshold_debounce_clear_enable_r;
  logic [NT-1:0] threshold_sample_enable_r;
  logic [2*NT-1:0] pin_threshold_irq_enable_r;
  logic [NV-1:0] bus_voltage_result_irq_enable_r;
  logic [2:0] cc_irq_enable_r;
  logic power_irq_enable_r;
  logic [2:0] top_irq_enable_r;
  logic clock_source_control_r;

  // Status registers
  logic [2*NT-1:0] pin_change_status_r;
  logic [NV-1:0] bus_voltage_change_status_r;
  logic [2:0] cc_flags_r;
  logic power_flag_r;
  logic done1_r, done2_r, all_done_d_r;
  logic hf_osc_r;
  logic [cc_detect_pkg::TICK_CNT_W-1:0] tick_cnt_r;
  logic tick_r;
  logic [31:0] prdata_r;

  // Synchronised comparator outputs and debouncer results
  cc_detect_pkg::cmp_sample_t cmp_sync;
  logic [NT-1:0] pin1_threshold_result, pin2_threshold_result;
  logic [NT-1:0] chg1, chg2;
  logic [NV-1:0] bus_voltage_result, vchg;
  logic first1, first2, vfirst;
  logic act1, act2, vact;

  // Bus decode
  wire setup = psel && !penable;
  wire wr = psel && penable && pwrite;
  wire sel_ccc = paddr == cc_detect_pkg::OFF_CC_CONTROL;
  wire sel_bvc = paddr == cc_detect_pkg::OFF_BUS_VOLTAGE_CONTROL;
  wire sel_mdb = paddr == cc_detect_pkg::OFF_MATCH_DEBOUNCE;
  wire sel_vdb = paddr == cc_detect_pkg::OFF_BUS_VOLTAGE_DEBOUNCE;
  wire sel_pdb = paddr == cc_detect_pkg::OFF_PD_SETTLE_DEBOUNCE;
  wire sel_dce = paddr == cc_detect_pkg::OFF_DEBOUNCE_CLEAR_EN;
  wire sel_sen = paddr == cc_detect_pkg::OFF_SAMPLE_EN;
  wire sel_pie = paddr == cc_detect_pkg::OFF_PIN_IRQ_EN;
  wire sel_th0 = paddr == cc_detect_pkg::OFF_BUS_THR_ZERO;
  wire sel_th1 = paddr == cc_detect_pkg::OFF_BUS_THR_ONE;
  wire sel_prs = paddr == cc_detect_pkg::OFF_PIN_RESULT;
  wire sel_pcs = paddr == cc_detect_pkg::OFF_PIN_CHANGE;
  wire sel_brs = paddr == cc_detect_pkg::OFF_BUS_RESULT;
  wire sel_bcs = paddr == cc_detect_pkg::OFF_BUS_CHANGE;
  wire sel_bie = paddr == cc_detect_pkg::OFF_BUS_IRQ_EN;
  wire sel_cis = paddr == cc_detect_pkg::OFF_CC_IRQ_STATUS;
  wire sel_cie = paddr == cc_detect_pkg::OFF_CC_IRQ_EN;
  wire sel_pis = paddr == cc_detect_pkg::OFF_POWER_IRQ_STATUS;
  wire sel_pwe = paddr == cc_detect_pkg::OFF_POWER_IRQ_EN;
  wire sel_tst = paddr == cc_detect_pkg::OFF_TOP_STATUS;
  wire sel_tie = paddr == cc_detect_pkg::OFF_TOP_IRQ_EN;
  wire sel_clk = paddr == cc_detect_pkg::OFF_CLOCK_CONTROL;
  wire mapped = sel_ccc | sel_bvc | sel_mdb | sel_vdb | sel_pdb | sel_dce |
    sel_sen | sel_pie | sel_th0 | sel_th1 | sel_prs | sel_pcs | sel_brs |
    sel_bcs | sel_bie | sel_cis | sel_cie | sel_pis | sel_pwe | sel_tst |
    sel_tie | sel_clk;

  // Comparator control fields; code zero stops sampling
  wire [1:0] cc_cmp = cc_control_r[cc_detect_pkg::CCC_CMP_LSB +: 2];
  wire [1:0] bus_cmp = bus_voltage_control_r[cc_detect_pkg::BVC_CMP_LSB +: 2];
  wire cc_deb_en = cc_control_r[cc_detect_pkg::CCC_DEB_EN];
  wire sink_role = cc_control_r[cc_detect_pkg::CCC_SINK];
  wire run1 = cc_cmp[0] && cc_deb_en;
  wire run2 = cc_cmp[1] && cc_deb_en;
  wire vrun = (bus_cmp != cc_detect_pkg::CMP_STOP) &&
    bus_voltage_control_r[cc_detect_pkg::BVC_DEB_EN];

  // Valid once every selected pin has finished its first debounce
  wire all_done = (run1 || run2) && (done1_r || !run1) &&
    (done2_r || !run2);
  wire valid_set = all_done && !all_done_d_r;
  wire pin1_set = |(chg1 & pin_threshold_irq_enable_r[NT-1:0]);
  wire pin2_set = |(chg2 & pin_threshold_irq_enable_r[2*NT-1:NT]);

  // Summaries; flags are sticky so the pin holds until cleared
  wire cc_summary_irq = |(cc_flags_r & cc_irq_enable_r);
  wire power_summary_irq = power_flag_r & power_irq_enable_r;
  wire bus_voltage_irq =
    |(bus_voltage_change_status_r & bus_voltage_result_irq_enable_r);
  wire [2:0] summaries = {bus_voltage_irq, power_summary_irq, cc_summary_irq};
  wire irq_any = |(summaries & top_irq_enable_r);

  // Highest of CC thresholds 0 to 2 met on either pin gives the advertised current
  wire [NT-1:0] cc_any = pin1_threshold_result | pin2_threshold_result;
  wire [1:0] level_nxt = !sink_role ? 2'h0 : cc_any[2] ? 2'h3 :
    cc_any[1] ? 2'h2 : cc_any[0] ? 2'h1 : 2'h0;

  // Read selection
  wire [31:0] rd_mux =
    sel_ccc ? {23'h0, cc_control_r} :
    sel_bvc ? {29'h0, bus_voltage_control_r} :
    sel_mdb ? {24'h0, match_debounce_time_r} :
    sel_vdb ? {24'h0, bus_voltage_debounce_time_r} :
    sel_pdb ? {24'h0, pd_settle_debounce_time_r} :
    sel_dce ? {28'h0, threshold_debounce_clear_enable_r} :
    sel_sen ? {28'h0, threshold_sample_enable_r} :
    sel_pie ? {24'h0, pin_threshold_irq_enable_r} :
    sel_th0 ? {22'h0, bus_thr_zero} :
    sel_th1 ? {22'h0, bus_thr_one} :
    sel_prs ? {24'h0, pin2_threshold_result, pin1_threshold_result} :
    sel_pcs ? {24'h0, pin_change_status_r} :
    sel_brs ? {30'h0, bus_voltage_result} :
    sel_bcs ? {30'h0, bus_voltage_change_status_r} :
    sel_bie ? {30'h0, bus_voltage_result_irq_enable_r} :
    sel_cis ? {29'h0, cc_flags_r} :
    sel_cie ? {29'h0, cc_irq_enable_r} :
    sel_pis ? {31'h0, power_flag_r} :
    sel_pwe ? {31'h0, power_irq_enable_r} :
    sel_tst ? {26'h0, hf_osc_r, vact, act1 | act2, summaries} :
    sel_tie ? {29'h0, top_irq_enable_r} :
    sel_clk ? {31'h0, clock_source_control_r} : 32'h0;

  // Zero-wait slave; unmapped addresses answer with an error
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata = prdata_r;

  // Analog controls straight from registers
  assign term.pin1_pulldown_en = sink_role;
  assign term.pin2_pulldown_en = sink_role;
  assign term.pin1_pulldown = cc_control_r[cc_detect_pkg::CCC_PD1_LSB +: 2];
  assign term.pin2_pulldown = cc_control_r[cc_detect_pkg::CCC_PD2_LSB +: 2];
  assign term.comm_sel = cc_control_r[cc_detect_pkg::CCC_COMM_SEL];
  assign cc_cmp_select = cc_cmp;
  assign bus_cmp_on = bus_cmp != cc_detect_pkg::CMP_STOP;
  assign hf_osc_en = hf_osc_r;

  // Comparator outputs are asynchronous to clk
  sync_two_flop #(.W($bits(cc_detect_pkg::cmp_sample_t))) u_sync (
    .clk(clk),
    .srst(srst),
    .d(cmp_raw),
    .q(cmp_sync)
  );

  // Debouncers; sample and clear enables pick the CC thresholds, both bus thresholds always enabled
  threshold_debouncer #(.W(NT), .CW(DW)) u_deb_pin1 (
    .clk(clk),
    .srst(srst),
    .tick(tick_r),
    .run(run1),
    .sample(cmp_sync.pin1),
    .sample_en(threshold_sample_enable_r),
    .clear_en(threshold_debounce_clear_enable_r),
    .interval(match_debounce_time_r),
    .result(pin1_threshold_result),
    .change(chg1),
    .first_done(first1),
    .active(act1)
  );

  threshold_debouncer #(.W(NT), .CW(DW)) u_deb_pin2 (
    .clk(clk),
    .srst(srst),
    .tick(tick_r),
    .run(run2),
    .sample(cmp_sync.pin2),
    .sample_en(threshold_sample_enable_r),
    .clear_en(threshold_debounce_clear_enable_r),
    .interval(match_debounce_time_r),
    .result(pin2_threshold_result),
    .change(chg2),
    .first_done(first2),
    .active(act2)
  );

  threshold_debouncer #(.W(NV), .CW(DW)) u_deb_bus (
    .clk(clk),
    .srst(srst),
    .tick(tick_r),
    .run(vrun),
    .sample(cmp_sync.vbus),
    .sample_en({NV{1'b1}}),
    .clear_en({NV{1'b1}}),
    .interval(bus_voltage_debounce_time_r),
    .result(bus_voltage_result),
    .change(vchg),
    .first_done(vfirst),
    .active(vact)
  );

  // Debounce time base; runs regardless of the fast-oscillator control
  always_ff @(posedge clk) begin
    if (srst || tick_cnt_r ==
        cc_detect_pkg::TICK_CNT_W'(cc_detect_pkg::DEB_UNIT_CYCLES - 1)) begin
      tick_cnt_r <= '0;
    end else begin
      tick_cnt_r <= tick_cnt_r + 1'b1;
    end
  end

  // One-cycle tick per debounce unit
  always_ff @(posedge clk) begin
    if (srst) tick_r <= 1'b0;
    else tick_r <= tick_cnt_r ==
      cc_detect_pkg::TICK_CNT_W'(cc_detect_pkg::DEB_UNIT_CYCLES - 1);
  end

  // Read data captured in the setup cycle
  always_ff @(posedge clk) begin
    if (srst) prdata_r <= 32'h0;
    else if (setup) prdata_r <= rd_mux;
  end

  // Detection control registers
  always_ff @(posedge clk) begin
    if (srst) begin
      cc_control_r <= cc_detect_pkg::CC_CONTROL_RST;
      bus_voltage_control_r <= cc_detect_pkg::BUS_CONTROL_RST;
      match_debounce_time_r <= cc_detect_pkg::DEBOUNCE_RST;
      bus_voltage_debounce_time_r <= cc_detect_pkg::DEBOUNCE_RST;
      pd_settle_debounce_time_r <= cc_detect_pkg::DEBOUNCE_RST;
      threshold_debounce_clear_enable_r <= '0;
      threshold_sample_enable_r <= '0;
      bus_thr_zero <= cc_detect_pkg::BUS_THR_RST;
      bus_thr_one <= cc_detect_pkg::BUS_THR_RST;
    end else if (wr) begin
      if (sel_ccc) cc_control_r <= pwdata[cc_detect_pkg::CCC_W-1:0];
      if (sel_bvc) bus_voltage_control_r <= pwdata[cc_detect_pkg::BVC_W-1:0];
      if (sel_mdb) match_debounce_time_r <= pwdata[DW-1:0];
      if (sel_vdb) bus_voltage_debounce_time_r <= pwdata[DW-1:0];
      if (sel_pdb) pd_settle_debounce_time_r <= pwdata[DW-1:0];
      if (sel_dce) threshold_debounce_clear_enable_r <= pwdata[NT-1:0];
      if (sel_sen) threshold_sample_enable_r <= pwdata[NT-1:0];
      if (sel_th0) bus_thr_zero <= pwdata[cc_detect_pkg::DAC_W-1:0];
      if (sel_th1) bus_thr_one <= pwdata[cc_detect_pkg::DAC_W-1:0];
    end
  end

  // Interrupt enable registers
  always_ff @(posedge clk) begin
    if (srst) begin
      pin_threshold_irq_enable_r <= '0;
      bus_voltage_result_irq_enable_r <= '0;
      cc_irq_enable_r <= 3'h0;
      power_irq_enable_r <= 1'b0;
      top_irq_enable_r <= 3'h0;
    end else if (wr) begin
      if (sel_pie) pin_threshold_irq_enable_r <= pwdata[2*NT-1:0];
      if (sel_bie) bus_voltage_result_irq_enable_r <= pwdata[NV-1:0];
      if (sel_cie) cc_irq_enable_r <= pwdata[2:0];
      if (sel_pwe) power_irq_enable_r <= pwdata[0];
      if (sel_tie) top_irq_enable_r <= pwdata[2:0];
    end
  end

  // Any access wakes the oscillator; clock control may stop it again
  always_ff @(posedge clk) begin
    if (srst) begin
      clock_source_control_r <= cc_detect_pkg::CLOCK_CONTROL_RST;
      hf_osc_r <= cc_detect_pkg::CLOCK_CONTROL_RST;
    end else if (wr && sel_clk) begin
      clock_source_control_r <= pwdata[0];
      hf_osc_r <= pwdata[0];
    end else if (setup) begin
      clock_source_control_r <= 1'b1;
      hf_osc_r <= 1'b1;
    end
  end

  // Initial-debounce tracking for the valid flag
  always_ff @(posedge clk) begin
    if (srst) begin
      done1_r <= 1'b0;
      done2_r <= 1'b0;
      all_done_d_r <= 1'b0;
    end else begin
      done1_r <= run1 && (done1_r || first1);
      done2_r <= run2 && (done2_r || first2);
      all_done_d_r <= all_done;
    end
  end

  // Sticky status, write one to clear; a same-cycle event wins
  always_ff @(posedge clk) begin
    if (srst) begin
      pin_change_status_r <= '0;
      bus_voltage_change_status_r <= '0;
      cc_flags_r <= 3'h0;
      power_flag_r <= 1'b0;
    end else begin
      pin_change_status_r <= (pin_change_status_r &
        ~((wr && sel_pcs) ? pwdata[2*NT-1:0] : '0)) | {chg2, chg1};
      bus_voltage_change_status_r <= (bus_voltage_change_status_r &
        ~((wr && sel_bcs) ? pwdata[NV-1:0] : '0)) | vchg;
      cc_flags_r <= (cc_flags_r & ~((wr && sel_cis) ? pwdata[2:0] : 3'h0)) |
        {pin2_set, pin1_set, valid_set};
      power_flag_r <= (power_flag_r & ~(wr && sel_pis && pwdata[0])) |
        vfirst;
    end
  end

  // Registered pin and charge level outputs
  always_ff @(posedge clk) begin
    if (srst) begin
      irq_n <= 1'b1;
      charge_level <= 2'h0;
    end else begin
      irq_n <= !irq_any;
      charge_level <= level_nxt;
    end
  end

endmodule
`default_nettype wire

// ---- sink_detect_sva.sv ----
// Port checker for sink attach and detach detection
`timescale 1ns/10ps
`default_nettype none
module sink_detect_sva (
  input wire logic clk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic pready,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire cc_detect_pkg::term_ctl_t term,
  input wire logic [1:0] cc_cmp_select,
  input wire logic bus_cmp_on,
  input wire logic [cc_detect_pkg::DAC_W-1:0] bus_thr_zero,
  input wire logic hf_osc_en,
  input wire logic [1:0] charge_level
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // Completed writes by offset; effects land one edge later
  wire wr = psel && penable && pready && pwrite;
  wire wr_cc = wr && paddr == 8'h00;
  wire wr_clk = wr && paddr == 8'h54;
  cc_stop_a: assert property (
    wr_cc && pwdata[1:0] == 2'h0 |=> cc_cmp_select == 2'h0)
    else $error("cc sampling not stopped");
  bus_stop_a: assert property (
    wr && paddr == 8'h04 && pwdata[1:0] == 2'h0 |=> !bus_cmp_on)
    else $error("bus sampling not stopped");
  sink_pull_a: assert property (
    wr_cc && pwdata[8] |=> term.pin1_pulldown_en && term.pin2_pulldown_en)
    else $error("sink pull-downs missing");
  pull_value_a: assert property (
    wr_cc |=> term[6:2] == $past(pwdata[7:3]))
    else $error("termination fields wrong");
  osc_wake_a: assert property (
    psel && !penable |=> hf_osc_en) else $error("oscillator not woken");
  osc_off_a: assert property (
    wr_clk && !pwdata[0] |=> !hf_osc_en) else $error("oscillator not off");
  dac_thr_a: assert property (
    wr && paddr == 8'h20 |=> bus_thr_zero == $past(pwdata[9:0]))
    else $error("threshold zero wrong");
  no_sink_a: assert property (
    !term.pin1_pulldown_en [*2] |-> charge_level == 2'h0)
    else $error("charge level outside sink role");
  // Main scenarios reached
  cover property (wr_cc && pwdata[8]);
  cover property (charge_level == 2'h3);
  cover property (wr_clk && !pwdata[0]);
endmodule
bind sink_cc_vbus_attach_detect sink_detect_sva i_sva (.clk, .srst, .psel,
  .penable, .pwrite, .pready, .paddr, .pwdata, .term, .cc_cmp_select,
  .bus_cmp_on, .bus_thr_zero, .hf_osc_en, .charge_level);
`default_nettype wire

// ---- sync_two_flop.sv ----
// Two-flop synchroniser for a vector of independent levels
`timescale 1ns/10ps
`default_nettype none
module sync_two_flop #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_r;

  // First stage feeds only the second stage
  always_ff @(posedge clk) begin
    if (srst) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end

endmodule
`default_nettype wire

// ---- test_sink_cc_vbus_attach_detect.sv ----
// Self-checking bench for sink attach and detach detection
`timescale 1ns/10ps
`default_nettype none
module test_sink_cc_vbus_attach_detect;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic attach = 1'b0;
  logic vbus_on = 1'b0;
  logic [1:0] level = 2'h2;
  logic [31:0] prdata, seed = 32'hC7DA;
  logic [31:0] r;
  logic pready, pslverr, bus_cmp_on, hf_osc_en, irq_n;
  logic [1:0] cc_cmp_select, charge_level;
  logic [9:0] thr0, thr1;
  cc_detect_pkg::term_ctl_t term;
  cc_detect_pkg::cmp_sample_t cmp_raw;
  logic [63:0] q[$], nt;
  int n_fail = 0;
  int checks = 0;
  always #20 clk = ~clk;
  sink_cc_vbus_attach_detect i_dut (.clk, .srst, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .cmp_raw, .term,
    .cc_cmp_select, .bus_cmp_on, .bus_thr_zero(thr0), .bus_thr_one(thr1),
    .hf_osc_en, .charge_level, .irq_n);
  port_partner i_far (.clk, .attach, .vbus_on, .level, .cc_cmp_select,
    .bus_cmp_on, .term, .cmp_raw);
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic cmp(string nm, logic [31:0] e, logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // One APB transfer; a read leaves its expected word and mask in the queue
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d,
                     logic [31:0] m = 32'hFFFFFFFF);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    if (!w) q.push_back({d, m});
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Pin level sampled mid-cycle, clear of the launching edge
  task automatic wait_irq(logic lv, int n);
    repeat (n) if (irq_n !== lv) @(negedge clk);
    cmp("irq_n", 32'(lv), 32'(irq_n));
  endtask
  // Completed reads against the oldest note
  always @(posedge clk) begin
    if (psel && penable && pready)
      cmp("pslverr", 32'(paddr == 8'h80), 32'(pslverr));
    if (psel && penable && pready && !pwrite) begin
      nt = q.pop_front();
      cmp("prdata", nt[63:32], prdata & nt[31:0]);
    end
  end
  // Watchdog well past the longest expected run
  initial begin
    #(40 * 90000);
    n_fail++;
    end_of_test();
  end
  initial begin
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    apb(0, 8'h4C, 32'h20, 32'h3F);
    apb(0, 8'h80, 32'h0);
    apb(1, 8'h00, 32'h100);
    apb(1, 8'h04, 32'h0);
    apb(0, 8'h4C, 32'h0, 32'h18);
    apb(1, 8'h08, 32'h1);
    apb(1, 8'h0C, 32'h2);
    apb(1, 8'h14, 32'hF);
    apb(1, 8'h18, 32'h7);
    apb(1, 8'h1C, 32'hFF);
    apb(1, 8'h38, 32'h3);
    apb(1, 8'h40, 32'h7);
    apb(1, 8'h48, 32'h1);
    apb(1, 8'h50, 32'h7);
    apb(1, 8'h20, rnd());
    r = rnd();
    apb(1, 8'h24, r);
    apb(0, 8'h24, r & 32'h3FF, 32'h3FF);
    apb(1, 8'h10, r);
    apb(0, 8'h10, r & 32'hFF, 32'hFF);
    attach <= 1'b1;
    apb(1, 8'h00, 32'h107 | (rnd() & 32'hF8));
    apb(0, 8'h4C, 32'h28, 32'h38);
    apb(1, 8'h54, 32'h0);
    wait_irq(1'b0, 9000);
    apb(0, 8'h3C, 32'h1, 32'h1);
    apb(0, 8'h28, 32'h3);
    cmp("charge_level", 32'h2, 32'(charge_level));
    apb(0, 8'h4C, 32'h21, 32'h21);
    apb(1, 8'h3C, 32'h7);
    apb(1, 8'h2C, 32'hFF);
    wait_irq(1'b1, 10);
    level <= 2'h3;
    wait_irq(1'b0, 9000);
    apb(0, 8'h2C, 32'h4);
    apb(0, 8'h3C, 32'h2, 32'h6);
    apb(1, 8'h2C, 32'hFF);
    apb(1, 8'h3C, 32'h7);
    apb(1, 8'h04, 32'h7);
    wait_irq(1'b0, 12000);
    apb(1, 8'h44, 32'h1);
    wait_irq(1'b1, 10);
    vbus_on <= 1'b1;
    wait_irq(1'b0, 12000);
    apb(0, 8'h30, 32'h3);
    apb(1, 8'h34, 32'h3);
    vbus_on <= 1'b0;
    repeat (1500) @(posedge clk);
    vbus_on <= 1'b1;
    repeat (8000) @(posedge clk);
    apb(0, 8'h34, 32'h0);
    apb(1, 8'h50, 32'h3);
    vbus_on <= 1'b0;
    repeat (9000) @(posedge clk);
    wait_irq(1'b1, 1);
    apb(0, 8'h30, 32'h0);
    apb(0, 8'h34, 32'h3);
    apb(1, 8'h50, 32'h7);
    wait_irq(1'b0, 10);
    apb(1, 8'h00, 32'h100);
    apb(1, 8'h04, 32'h0);
    apb(0, 8'h4C, 32'h0, 32'h18);
    apb(1, 8'h00, 32'h0);
    repeat (2) @(negedge clk);
    cmp("charge_level", 32'h0, 32'(charge_level));
    end_of_test();
  end
endmodule
`default_nettype wire

// ---- threshold_debouncer.sv ----
// Debouncer for a group of comparator thresholds
`timescale 1ns/10ps
`default_nettype none
module threshold_debouncer #(
  parameter int W = 4,
  parameter int CW = 8
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic tick,
  input wire logic run,
  input wire logic [W-1:0] sample,
  input wire logic [W-1:0] sample_en,
  input wire logic [W-1:0] clear_en,
  input wire logic [CW-1:0] interval,
  output logic [W-1:0] result,
  output logic [W-1:0] change,
  output logic first_done,
  output logic active
);

  logic [W-1:0] cand_r;
  logic [CW-1:0] cnt_r;
  logic seen_r;

  // Unsampled thresholds are held at zero
  wire [W-1:0] masked = sample & sample_en;
  wire moved = masked != cand_r;
  wire stable = !moved && (cnt_r >= interval);
  wire [W-1:0] upd = (cand_r ^ result) & clear_en;

  // Widths below one cannot be served; refused at elaboration
  if (W < 1 || CW < 1) begin : g_bad_width
    $error("threshold_debouncer: bad width");
  end

  // Active follows run one cycle later
  always_ff @(posedge clk) begin
    if (srst) active <= 1'b0;
    else active <= run;
  end

  // Count only while the candidate holds; any move restarts
  always_ff @(posedge clk) begin
    if (srst || !run) begin
      cand_r <= '0;
      cnt_r <= '0;
    end else if (moved) begin
      cand_r <= masked;
      cnt_r <= '0;
    end else if (tick && cnt_r < interval) begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

  // First settle loads all; later settles report changes
  always_ff @(posedge clk) begin
    if (srst) begin
      result <= '0;
      seen_r <= 1'b0;
      change <= '0;
      first_done <= 1'b0;
    end else if (!run) begin
      seen_r <= 1'b0;
      change <= '0;
      first_done <= 1'b0;
    end else begin
      change <= '0;
      first_done <= 1'b0;
      if (stable && !seen_r) begin
        result <= cand_r;
        seen_r <= 1'b1;
        first_done <= 1'b1;
      end else if (stable && |upd) begin
        result <= result ^ upd;
        change <= upd;
      end
    end
  end

endmodule
`default_nettype wire
